// >>> shared/tio_pkg.sv
// package: register map, field positions and pin carrier of the i/o control block
package tio_pkg;
    // register byte offsets
    localparam logic [4:0] TIO_OFF_CTRL = 5'h00;
    localparam logic [4:0] TIO_OFF_GR0A = 5'h04;
    localparam logic [4:0] TIO_OFF_GR0C = 5'h08;
    localparam logic [4:0] TIO_OFF_GR1A = 5'h0c;
    localparam logic [4:0] TIO_OFF_STAT = 5'h10;
    localparam logic [4:0] TIO_OFF_MASK = 5'h14;
    localparam logic [4:0] TIO_OFF_PINS = 5'h18;
    // control register field positions
    localparam int TIO_POS_A0 = 0;
    localparam int TIO_POS_C0 = 4;
    localparam int TIO_POS_A1 = 8;
    localparam int TIO_POS_BFA = 16;
    // reset values
    localparam logic [3:0] TIO_FIELD_RST = 4'h0;
    localparam logic [15:0] TIO_GR_RST = 16'hffff;
    localparam logic [2:0] TIO_EV_RST = 3'h0;
    // index of each general register in vectors
    localparam int TIO_I_A0 = 0;
    localparam int TIO_I_C0 = 1;
    localparam int TIO_I_A1 = 2;
    // one bit per compare/capture pin
    typedef struct packed {
        logic a1;
        logic c0;
        logic a0;
    } tio_pins_t;
endpackage

// >>> rtl/tio_io_ctrl.sv
// i/o control for general registers a and c of timer channel 0 and general register a of channel 1
`timescale 1ns/100ps
// How it works
// (R01) a-register field bits 3..0 select compare output or capture
// (R02) c-register field selects its function the same way
// (R03) top bit 0 with low bits 00 disables output; reset is 0000
// (R04) compare mode initial pin level is field bit 2
// (R05) low bits 01: pin goes low on compare match
// (R06) low bits 10: pin goes high on compare match
// (R07) low bits 11: pin toggles on compare match
// (R08) code 1000 captures counter on rising pin edge
// (R09) code 1001 captures counter on falling pin edge
// (R10) code 101x captures counter on both pin edges
// (R11) channel 0 code 11xx takes capture source from channel 1 counting
// (R12) that source captures on every channel 1 count up or down
// (R13) buffer enable a set: c field ignored, no capture or compare
// (R14) channel 1 a code 11xx captures on channel 0 a match or capture
// (R15) disabled or capture mode: matches leave pin level untouched
module tio_io_ctrl
    import tio_pkg::*;
#(
    parameter int CW = 16
)
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [CW-1:0] ch0_count,
    input wire logic [CW-1:0] ch1_counter,
    input wire logic ch1_count_up,
    input wire logic ch1_count_down,
    input wire tio_pins_t pin_i,
    output tio_pins_t pin_o,
    output tio_pins_t pin_oe,
    output logic irq
);
    logic [3:0] a_reg_function_field_q;
    logic [3:0] c_reg_function_field_q;
    logic [3:0] ch1_a_field_q;
    logic buffer_enable_a_q;
    logic [CW-1:0] gr_q [3];
    logic [2:0] status_q;
    logic [2:0] mask_q;
    logic [2:0] level_q;
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [2:0] sync3_q;
    logic [2:0] eq_q;
    logic rvalid_q;
    logic [3:0] fld [3];
    logic [2:0] active;
    logic [2:0] eq;
    logic [2:0] match;
    logic [2:0] cap;
    logic [2:0] ev;
    logic [2:0] rise;
    logic [2:0] fall;
    logic [2:0] internal;
    logic [CW-1:0] cnt [3];
    logic [31:0] ctrl_word;
    logic wr_ctrl;
    logic [31:0] rd_d;

    // word merge under byte enables
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction

    // compare output enabled for a field
    function automatic logic oc_on(input logic [3:0] f);
        return !f[3] && (f[1:0] != 2'b00);
    endfunction

    // capture decode: pin edges or internal source
    function automatic logic cap_hit(input logic [3:0] f, input logic r, input logic fl,
                                     input logic intl);
        logic h;
        h = 1'b0;
        if (f[3] && f[2])
            h = intl; // R11 R14
        else if (f[3] && f[1])
            h = r | fl; // R10
        else if (f[3] && f[0])
            h = fl; // R09
        else if (f[3])
            h = r; // R08
        return h;
    endfunction

    // compare output next level
    function automatic logic oc_next(input logic [3:0] f, input logic lvl);
        logic n;
        unique case (f[1:0])
            2'b01: n = 1'b0; // R05
            2'b10: n = 1'b1; // R06
            2'b11: n = ~lvl; // R07
            2'b00: n = lvl;
        endcase
        return n;
    endfunction

    // field and counter routing per register
    assign fld[TIO_I_A0] = a_reg_function_field_q; // R01
    assign fld[TIO_I_C0] = c_reg_function_field_q; // R02
    assign fld[TIO_I_A1] = ch1_a_field_q;
    assign cnt[TIO_I_A0] = ch0_count;
    assign cnt[TIO_I_C0] = ch0_count;
    assign cnt[TIO_I_A1] = ch1_counter;
    assign active = {1'b1, ~buffer_enable_a_q, 1'b1}; // R13
    assign internal[TIO_I_A0] = ch1_count_up | ch1_count_down; // R12
    assign internal[TIO_I_C0] = ch1_count_up | ch1_count_down; // R12
    assign internal[TIO_I_A1] = ev[TIO_I_A0]; // R14
    assign rise = sync2_q & ~sync3_q;
    assign fall = ~sync2_q & sync3_q;

    // match and capture events
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            eq[i] = cnt[i] == gr_q[i];
            match[i] = active[i] && !fld[i][3] && eq[i] && !eq_q[i];
            cap[i] = active[i] && cap_hit(fld[i], rise[i], fall[i], internal[i]);
        end
    end
    assign ev = match | cap;

    // pin synchronisers and edge history
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            sync3_q <= 3'h0;
        end
        else
        begin
            sync1_q <= pin_i;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // match edge history
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            eq_q <= 3'h0;
        else
            eq_q <= eq;
    end

    // bus write decode
    assign wr_ctrl = avs_write && avs_address == TIO_OFF_CTRL;
    assign ctrl_word = be_merge({15'h0, buffer_enable_a_q, 4'h0, ch1_a_field_q,
                                 c_reg_function_field_q, a_reg_function_field_q},
                                avs_writedata, avs_byteenable);

    // control fields
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            a_reg_function_field_q <= TIO_FIELD_RST; // R03
            c_reg_function_field_q <= TIO_FIELD_RST; // R03
            ch1_a_field_q <= TIO_FIELD_RST; // R03
            buffer_enable_a_q <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            a_reg_function_field_q <= ctrl_word[TIO_POS_A0 +: 4];
            c_reg_function_field_q <= ctrl_word[TIO_POS_C0 +: 4];
            ch1_a_field_q <= ctrl_word[TIO_POS_A1 +: 4];
            buffer_enable_a_q <= ctrl_word[TIO_POS_BFA];
        end
    end

    // pin levels: initial level on control write, else compare action
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            level_q <= 3'h0;
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (wr_ctrl && !ctrl_word[4*i+3])
                    level_q[i] <= ctrl_word[4*i+2]; // R04
                else if (match[i] && oc_on(fld[i]))
                    level_q[i] <= oc_next(fld[i], level_q[i]); // R05 R06 R07
            end
        end
    end
    assign pin_o = level_q;
    always_comb
    begin
        for (int i = 0; i < 3; i++)
            pin_oe[i] = active[i] && oc_on(fld[i]); // R03 R15
    end

    // general registers: capture wins over a bus write
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < 3; i++)
                gr_q[i] <= CW'(TIO_GR_RST);
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (cap[i])
                    gr_q[i] <= cnt[i]; // R08 R09 R10 R12 R14
                else if (avs_write && avs_address == TIO_OFF_GR0A + 5'(4*i))
                    gr_q[i] <= CW'(be_merge(32'(gr_q[i]), avs_writedata, avs_byteenable));
            end
        end
    end

    // sticky status, write one to clear, set wins
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            status_q <= TIO_EV_RST;
        else if (avs_write && avs_address == TIO_OFF_STAT && avs_byteenable[0])
            status_q <= (status_q & ~avs_writedata[2:0]) | ev;
        else
            status_q <= status_q | ev;
    end

    // interrupt mask
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            mask_q <= TIO_EV_RST;
        else if (avs_write && avs_address == TIO_OFF_MASK && avs_byteenable[0])
            mask_q <= avs_writedata[2:0];
    end
    assign irq = |(status_q & mask_q);

    // read mux, unmapped reads zero
    always_comb
    begin
        rd_d = 32'h0;
        unique case (avs_address)
            TIO_OFF_CTRL: rd_d = {15'h0, buffer_enable_a_q, 4'h0, ch1_a_field_q,
                                  c_reg_function_field_q, a_reg_function_field_q};
            TIO_OFF_GR0A: rd_d = 32'(gr_q[TIO_I_A0]);
            TIO_OFF_GR0C: rd_d = 32'(gr_q[TIO_I_C0]);
            TIO_OFF_GR1A: rd_d = 32'(gr_q[TIO_I_A1]);
            TIO_OFF_STAT: rd_d = {29'h0, status_q};
            TIO_OFF_MASK: rd_d = {29'h0, mask_q};
            TIO_OFF_PINS: rd_d = {25'h0, sync2_q, 1'b0, level_q};
            default: rd_d = 32'h0;
        endcase
    end

    // reads take one wait cycle; writes complete at once
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rvalid_q <= 1'b0;
            avs_readdata <= 32'h0;
        end
        else
        begin
            rvalid_q <= avs_read && !rvalid_q;
            if (avs_read && !rvalid_q)
                avs_readdata <= rd_d;
        end
    end
    assign avs_waitrequest = avs_read && !rvalid_q;

    // assertions
    // a full-word control write that sets one field to a given code
    sequence ctrl_wr_s(int p, logic [3:0] code);
        wr_ctrl && avs_byteenable == 4'hf && avs_writedata[p +: 4] == code;
    endsequence

    // compare output: enable, initial level and match actions
    dis_no_drive_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R03
        ctrl_wr_s(TIO_POS_A0, 4'h4) |=> !pin_oe.a0 until wr_ctrl)
        else $error("disabled code still drives pin a0");
    init_low_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R04
        ctrl_wr_s(TIO_POS_A0, 4'h1) |=> !pin_o.a0 && pin_oe.a0)
        else $error("initial low level missing");
    init_high_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R04
        ctrl_wr_s(TIO_POS_A1, 4'h6) |=> pin_o.a1 && pin_oe.a1)
        else $error("initial high level missing");
    match_low_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R05
        match[0] && fld[0] inside {4'h1, 4'h5} && !wr_ctrl |=> !pin_o.a0)
        else $error("match did not drive low");
    match_high_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R06
        match[2] && fld[2] inside {4'h2, 4'h6} && !wr_ctrl |=> pin_o.a1)
        else $error("match did not drive high");
    toggle_out_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R07
        match[0] && fld[0] == 4'h3 && !wr_ctrl |=> pin_o.a0 != $past(pin_o.a0))
        else $error("match did not toggle");
    // capture: pin edges three edges after the pin moves
    rise_cap_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R08
        fld[0] == 4'h8 && $rose(sync2_q[0]) |=> gr_q[0] == $past(ch0_count))
        else $error("rising edge capture missed");
    fall_cap_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R09
        fld[2] == 4'h9 && $fell(sync2_q[2]) |=> gr_q[2] == $past(ch1_counter))
        else $error("falling edge capture missed");
    pin_to_cap_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R10
        fld[0] == 4'ha && pin_i.a0 != sync1_q[0] |-> ##2 cap[0])
        else $error("both edge capture not two cycles after pin change");
    // internal sources, buffering and chaining
    int_cap_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R12
        fld[1][3:2] == 2'b11 && !buffer_enable_a_q && (ch1_count_up || ch1_count_down)
        |=> gr_q[1] == $past(ch0_count))
        else $error("count source capture missed");
    buf_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R13
        buffer_enable_a_q |-> !pin_oe.c0 && !cap[1] && !match[1])
        else $error("buffered c register still active");
    chain_cap_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R14
        fld[2][3:2] == 2'b11 && match[0] |=> status_q[2] && gr_q[2] == $past(ch1_counter))
        else $error("chained capture missed");
    // capture mode never moves the driven level
    cap_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // R15
        fld[0][3] && !wr_ctrl |=> $stable(pin_o.a0))
        else $error("pin level moved in capture mode");
endmodule

// >>> verif/tio_pin_model.sv
// far side model: outside circuitry on the compare/capture pins
`timescale 1ns/100ps
module tio_pin_model
    import tio_pkg::*;
(
    input wire tio_pins_t ext_lvl,
    input wire tio_pins_t pin_o,
    input wire tio_pins_t pin_oe,
    output tio_pins_t pin_i
);
    // wire level: block drive where enabled, outside source elsewhere
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_lvl);
endmodule

// >>> verif/tio_io_ctrl_bench.sv
// self-checking bench for the timer i/o control block
`timescale 1ns/100ps
module tio_io_ctrl_bench
    import tio_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [15:0] ch0_count = 16'h0;
    logic [15:0] ch1_counter = 16'h0;
    logic ch1_count_up = 1'b0;
    logic ch1_count_down = 1'b0;
    tio_pins_t ext_lvl = 3'h0;
    tio_pins_t pin_i;
    tio_pins_t pin_o;
    tio_pins_t pin_oe;
    logic irq;
    int bad_count = 0;
    int comparisons = 0;
    int cyc = 0;

    // design and outside pin circuitry
    tio_io_ctrl #(.CW(16)) dut (.sys_clk, .rst_b, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .ch0_count,
        .ch1_counter, .ch1_count_up, .ch1_count_down, .pin_i, .pin_o, .pin_oe, .irq);
    tio_pin_model pins (.ext_lvl, .pin_o, .pin_oe, .pin_i);

    // 250 mhz clock
    always #2 sys_clk = ~sys_clk;

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // hang guard
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            test_done();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic pchk(input string what, input logic exp, input logic got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // bus write: hold until waitrequest low at a rising edge
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do
            @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask

    // bus read: data taken in the cycle that ends the wait
    task automatic rchk(input string what, input logic [4:0] a, input logic [31:0] exp);
        logic [31:0] v;
        avs_address <= a;
        avs_read <= 1'b1;
        do
            @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0);
        v = avs_readdata;
        avs_read <= 1'b0;
        @(posedge sys_clk);
        chk(what, exp, v);
    endtask

    task automatic reset_values();
        rchk("ctrl", TIO_OFF_CTRL, 32'h0);
        rchk("gr0a", TIO_OFF_GR0A, {16'h0, TIO_GR_RST});
        rchk("unmapped", 5'h1c, 32'h0);
        chk("oe", 32'h0, {29'h0, pin_oe});
    endtask

    task automatic compare_codes();
        logic [3:0] code;
        logic lvl;
        wr(TIO_OFF_GR0A, 32'h10);
        for (int i = 0; i < 8; i++)
        begin
            code = 4'(i);
            ch0_count <= 16'h0;
            wr(TIO_OFF_CTRL, {28'h0, code});
            lvl = code[2];
            pchk("a0 oe", code[1:0] != 2'b00, pin_oe.a0);
            pchk("a0 init", lvl, pin_o.a0);
            case (code[1:0])
                2'b01: lvl = 1'b0;
                2'b10: lvl = 1'b1;
                2'b11: lvl = ~lvl;
                default: lvl = lvl;
            endcase
            ch0_count <= 16'h10;
            tick(3);
            pchk("a0 match", lvl, pin_o.a0);
        end
    endtask

    task automatic capture_codes();
        logic [31:0] r;
        for (int i = 8; i < 12; i++)
        begin
            ext_lvl.a0 <= 1'b0;
            wr(TIO_OFF_CTRL, 32'(i));
            tick(4);
            wr(TIO_OFF_GR0A, 32'h0);
            ch0_count <= 16'h100 + 16'(i);
            ext_lvl.a0 <= 1'b1;
            tick(5);
            r = (i == 9) ? 32'h0 : 32'h100 + 32'(i);
            rchk("rise cap", TIO_OFF_GR0A, r);
            ch0_count <= 16'h200 + 16'(i);
            ext_lvl.a0 <= 1'b0;
            tick(5);
            rchk("fall cap", TIO_OFF_GR0A, (i == 8) ? r : 32'h200 + 32'(i));
        end
    endtask

    task automatic irq_flow();
        wr(TIO_OFF_MASK, 32'h0);
        rchk("stat", TIO_OFF_STAT, 32'h1);
        pchk("irq off", 1'b0, irq);
        wr(TIO_OFF_MASK, 32'h1);
        pchk("irq on", 1'b1, irq);
        wr(TIO_OFF_STAT, 32'h1);
        pchk("irq clr", 1'b0, irq);
        rchk("stat clr", TIO_OFF_STAT, 32'h0);
    endtask

    task automatic internal_src();
        ch0_count <= 16'h0;
        wr(TIO_OFF_GR0A, 32'h10);
        wr(TIO_OFF_CTRL, 32'hcc1);
        wr(TIO_OFF_GR0C, 32'h0);
        ch0_count <= 16'h33;
        ch1_count_up <= 1'b1;
        tick(1);
        ch1_count_up <= 1'b0;
        tick(4);
        rchk("up cap", TIO_OFF_GR0C, 32'h33);
        ch0_count <= 16'h44;
        ch1_count_down <= 1'b1;
        tick(1);
        ch1_count_down <= 1'b0;
        tick(4);
        rchk("down cap", TIO_OFF_GR0C, 32'h44);
        ch1_counter <= 16'h77;
        ch0_count <= 16'h10;
        tick(5);
        rchk("a1 cap", TIO_OFF_GR1A, 32'h77);
    endtask

    // channel 1 a: initial high, drive high on match, falling capture
    task automatic ch1_codes();
        ch1_counter <= 16'h0;
        wr(TIO_OFF_GR1A, 32'h50);
        wr(TIO_OFF_CTRL, 32'h600);
        pchk("a1 init high", 1'b1, pin_o.a1);
        pchk("a1 oe", 1'b1, pin_oe.a1);
        wr(TIO_OFF_CTRL, 32'h200);
        pchk("a1 init low", 1'b0, pin_o.a1);
        ch1_counter <= 16'h50;
        tick(3);
        pchk("a1 match high", 1'b1, pin_o.a1);
        ext_lvl.a1 <= 1'b1;
        wr(TIO_OFF_CTRL, 32'h900);
        tick(4);
        ch1_counter <= 16'h66;
        ext_lvl.a1 <= 1'b0;
        tick(5);
        rchk("a1 fall cap", TIO_OFF_GR1A, 32'h66);
    endtask

    task automatic buffer_mode();
        ch0_count <= 16'h0;
        wr(TIO_OFF_CTRL, 32'h10010);
        wr(TIO_OFF_GR0C, 32'h20);
        wr(TIO_OFF_STAT, 32'h7);
        pchk("c0 oe", 1'b0, pin_oe.c0);
        ch0_count <= 16'h20;
        tick(5);
        rchk("c0 silent", TIO_OFF_STAT, 32'h0);
    endtask

    // main sequence
    initial
    begin
        tick(3);
        rst_b <= 1'b1;
        tick(1);
        reset_values();
        compare_codes();
        capture_codes();
        irq_flow();
        internal_src();
        ch1_codes();
        buffer_mode();
        test_done();
    end
endmodule
